// >>> hdl/cond_branch_pkg.sv
// Summary of operation
// - Opcode E6h branches only when the negative flag is one.
// - Opcode E3h branches only when the carry flag is zero.
// - Opcode E7h branches only when the negative flag is zero.
// - Opcode E5h branches only when the overflow flag is zero.
// - Opcode E1h branches only when the zero flag is zero.
// - Low byte is a signed offset, sign-extended and doubled.
// - Taken target is address plus 2 plus doubled offset; else plus 2.
// - One cycle if not taken; two if taken, second cycle is a no-op.
package cond_branch_pkg;

  // ==========================================================
  // Opcode high bytes.
  localparam logic [7:0] OPC_BRANCH_IF_NEGATIVE     = 8'hE6;
  localparam logic [7:0] OPC_BRANCH_IF_CARRY_CLEAR  = 8'hE3;
  localparam logic [7:0] OPC_BRANCH_IF_NOT_NEGATIVE = 8'hE7;
  localparam logic [7:0] OPC_BRANCH_IF_NO_OVERFLOW  = 8'hE5;
  localparam logic [7:0] OPC_BRANCH_IF_NONZERO      = 8'hE1;

  // ==========================================================
  // Field positions and sizes.
  localparam int OPC_MSB      = 15;
  localparam int OPC_LSB      = 8;
  localparam int OFFSET_MSB   = 7;
  localparam int WORD_BYTES   = 2;
  localparam int PHASES       = 4;

  // Reset values.
  localparam logic [1:0] PHASE_RESET = 2'h0;

  // Instruction cycle states.
  typedef enum logic [1:0] {
    ST_EXEC,
    ST_FLUSH
  } cycle_state_t;

endpackage

// >>> hdl/phase_divider.sv
`timescale 1ns/10ps
// Divides the core clock into four phase pulses per instruction cycle.
module phase_divider (
  // Clock and reset.
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  // Phase outputs.
  output logic [1:0]      phase_o,
  output logic            q4_o
);
  import cond_branch_pkg::*;

  logic [1:0] phase_reg;
  logic [1:0] phase_next;

  // Next phase wraps after the fourth.
  always_comb begin
    phase_next = phase_reg + 2'h1;
  end

  // Phase register.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_reg <= PHASE_RESET;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Outputs.
  assign phase_o = phase_reg;
  assign q4_o    = (phase_reg == 2'(PHASES - 1));

endmodule

// >>> hdl/cond_branch_on_flag_unit.sv
`timescale 1ns/10ps
// Executes five conditional relative branches on status flags.
module cond_branch_on_flag_unit #(
  parameter int ADDR_W = 21
) (
  // Clock and reset.
  input  wire logic              sys_clk_i,
  input  wire logic              resetn_i,
  // Instruction from the fetch pipeline, held for a whole cycle.
  input  wire logic              instr_valid_i,
  input  wire logic [15:0]       instr_i,
  input  wire logic [ADDR_W-1:0] instr_addr_i,
  // Status flags.
  input  wire logic              flag_negative_i,
  input  wire logic              flag_overflow_i,
  input  wire logic              flag_zero_i,
  input  wire logic              flag_carry_i,
  // Program counter side.
  output logic                   program_counter_we_o,
  output logic [ADDR_W-1:0]      program_counter_o,
  output logic                   flush_o,
  output logic                   is_branch_o,
  output logic                   status_we_o,
  output logic [1:0]             phase_o,
  output logic                   cycle_start_o
);
  import cond_branch_pkg::*;

  // ==========================================================
  // Decode helpers.

  // Returns one when the opcode is one of the five branches.
  function automatic logic is_cond_branch(input logic [7:0] opc);
    return (opc == OPC_BRANCH_IF_NEGATIVE) ||
           (opc == OPC_BRANCH_IF_CARRY_CLEAR) ||
           (opc == OPC_BRANCH_IF_NOT_NEGATIVE) ||
           (opc == OPC_BRANCH_IF_NO_OVERFLOW) ||
           (opc == OPC_BRANCH_IF_NONZERO);
  endfunction

  // Evaluates the branch condition for an opcode.
  function automatic logic cond_met(input logic [7:0] opc,
                                    input logic n, input logic c,
                                    input logic v, input logic z);
    logic r;
    r = 1'b0;
    if (opc == OPC_BRANCH_IF_NEGATIVE) begin
      r = n;
    end else if (opc == OPC_BRANCH_IF_CARRY_CLEAR) begin
      r = !c;
    end else if (opc == OPC_BRANCH_IF_NOT_NEGATIVE) begin
      r = !n;
    end else if (opc == OPC_BRANCH_IF_NO_OVERFLOW) begin
      r = !v;
    end else if (opc == OPC_BRANCH_IF_NONZERO) begin
      r = !z;
    end
    return r;
  endfunction

  // ==========================================================
  // Phase generation.
  logic [1:0] phase;
  logic       q4;

  phase_divider u_phase (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .phase_o   (phase),
    .q4_o      (q4)
  );

  // ==========================================================
  // Pipeline of the four phases.
  cycle_state_t      state_reg,   state_next;
  logic              decoded_reg, decoded_next;
  logic [7:0]        opc_reg,     opc_next;
  logic [ADDR_W-1:0] disp_reg,    disp_next;
  logic [ADDR_W-1:0] target_reg,  target_next;
  logic              take_reg,    take_next;
  logic              pc_we_reg,   pc_we_next;
  logic [ADDR_W-1:0] pc_reg,      pc_next;

  // Phase-stepped next values.
  always_comb begin
    state_next   = state_reg;
    decoded_next = decoded_reg;
    opc_next     = opc_reg;
    disp_next    = disp_reg;
    target_next  = target_reg;
    take_next    = take_reg;
    pc_we_next   = 1'b0;
    pc_next      = pc_reg;
    unique case (phase)
      2'h0: begin
        // Q1 decodes, unless this cycle is the flush no-op.
        if (state_reg == ST_FLUSH) begin
          decoded_next = 1'b0;
        end else begin
          opc_next     = instr_i[OPC_MSB:OPC_LSB];
          decoded_next = instr_valid_i &&
                         is_cond_branch(instr_i[OPC_MSB:OPC_LSB]);
        end
        take_next = 1'b0;
      end
      2'h1: begin
        // Q2 reads the literal, sign-extended and doubled.
        disp_next = ADDR_W'({{(ADDR_W-OFFSET_MSB-1){instr_i[OFFSET_MSB]}},
                             instr_i[OFFSET_MSB:0]} << 1);
      end
      2'h2: begin
        // Q3 forms the target and evaluates the flag.
        target_next = instr_addr_i + ADDR_W'(WORD_BYTES) + disp_reg;
        take_next   = decoded_reg && cond_met(opc_reg, flag_negative_i,
                        flag_carry_i, flag_overflow_i, flag_zero_i);
      end
      2'h3: begin
        // Q4 writes the counter only on a taken branch.
        if (take_reg) begin
          pc_we_next = 1'b1;
          pc_next    = target_reg;
          state_next = ST_FLUSH;
        end else begin
          state_next = ST_EXEC;
        end
      end
    endcase
  end

  // Pipeline registers.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg   <= ST_EXEC;
      decoded_reg <= 1'b0;
      opc_reg     <= 8'h00;
      disp_reg    <= '0;
      target_reg  <= '0;
      take_reg    <= 1'b0;
      pc_we_reg   <= 1'b0;
      pc_reg      <= '0;
    end else begin
      state_reg   <= state_next;
      decoded_reg <= decoded_next;
      opc_reg     <= opc_next;
      disp_reg    <= disp_next;
      target_reg  <= target_next;
      take_reg    <= take_next;
      pc_we_reg   <= pc_we_next;
      pc_reg      <= pc_next;
    end
  end

  // ==========================================================
  // Outputs.
  assign program_counter_we_o = pc_we_reg;
  assign program_counter_o    = pc_reg;
  assign flush_o              = (state_reg == ST_FLUSH);
  assign is_branch_o          = decoded_reg;
  assign status_we_o          = 1'b0;
  assign phase_o              = phase;
  assign cycle_start_o        = (phase == PHASE_RESET);

endmodule

// >>> tb/fetch_pc_model.sv
`timescale 1ns/10ps
// ====================
// Fetch-side program counter model.
module fetch_pc_model #(
  parameter int ADDR_W = 21
) (
  // Clock and reset.
  input  wire logic              sys_clk_i,
  input  wire logic              resetn_i,
  // Branch unit side.
  input  wire logic [1:0]        phase_i,
  input  wire logic              pc_we_i,
  input  wire logic [ADDR_W-1:0] pc_i,
  output logic      [ADDR_W-1:0] addr_o
);
  logic skip_reg;
  // Steps one word per cycle; a write jumps and skips the next step.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_o   <= '0;
      skip_reg <= 1'b0;
    end else if (pc_we_i) begin
      addr_o   <= pc_i;
      skip_reg <= 1'b1;
    end else if (phase_i == 2'h3) begin
      addr_o   <= skip_reg ? addr_o : addr_o + ADDR_W'(2);
      skip_reg <= 1'b0;
    end
  end
endmodule

// >>> tb/branch_unit_chk.sv
`timescale 1ns/10ps
// ====================
// Port checker for the branch unit.
module branch_unit_chk
  import cond_branch_pkg::*;
#(
  parameter int ADDR_W = 21
) (
  input wire logic              sys_clk_i,
  input wire logic              resetn_i,
  input wire logic              instr_valid_i,
  input wire logic [15:0]       instr_i,
  input wire logic [ADDR_W-1:0] instr_addr_i,
  input wire logic              flag_negative_i,
  input wire logic              flag_overflow_i,
  input wire logic              flag_zero_i,
  input wire logic              flag_carry_i,
  input wire logic              program_counter_we_o,
  input wire logic [ADDR_W-1:0] program_counter_o,
  input wire logic              flush_o,
  input wire logic              is_branch_o,
  input wire logic              status_we_o,
  input wire logic [1:0]        phase_o,
  input wire logic              cycle_start_o
);
  logic [7:0]        op;
  logic              take;
  logic [ADDR_W-1:0] tgt;
  logic              isb;
  logic              dec;
  // Expected decision and target of the instruction on the inputs.
  assign op = instr_i[15:8];
  assign take = instr_valid_i && !flush_o && (
    op == OPC_BRANCH_IF_NEGATIVE && flag_negative_i ||
    op == OPC_BRANCH_IF_CARRY_CLEAR && !flag_carry_i ||
    op == OPC_BRANCH_IF_NOT_NEGATIVE && !flag_negative_i ||
    op == OPC_BRANCH_IF_NO_OVERFLOW && !flag_overflow_i ||
    op == OPC_BRANCH_IF_NONZERO && !flag_zero_i);
  // Expected decode of the instruction on the inputs.
  assign isb = op == OPC_BRANCH_IF_NEGATIVE ||
    op == OPC_BRANCH_IF_CARRY_CLEAR ||
    op == OPC_BRANCH_IF_NOT_NEGATIVE ||
    op == OPC_BRANCH_IF_NO_OVERFLOW ||
    op == OPC_BRANCH_IF_NONZERO;
  assign dec = instr_valid_i && !flush_o && isb;
  assign tgt = instr_addr_i + ADDR_W'(2)
    + ADDR_W'({{(ADDR_W-8){instr_i[7]}}, instr_i[7:0], 1'b0});
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  a_taken_write: assert property (
    phase_o == 2'h2 && take |-> ##2 program_counter_we_o
    && program_counter_o == $past(tgt, 2)) else $error("bad target");
  a_untaken_quiet: assert property (
    phase_o == 2'h2 && !take |-> ##2 !program_counter_we_o)
    else $error("write when not taken");
  a_write_once: assert property (
    program_counter_we_o |=> !program_counter_we_o) else $error("long write");
  a_write_phase: assert property (
    program_counter_we_o |-> phase_o == 2'h0 && flush_o)
    else $error("write out of place");
  a_flush_len: assert property (
    $rose(flush_o) |-> flush_o [*4] ##1 !flush_o) else $error("flush length");
  a_status_quiet: assert property (
    !status_we_o) else $error("status written");
  a_phase_wrap: assert property (
    phase_o == 2'h3 |=> phase_o == 2'h0) else $error("phase wrap");
  a_cycle_mark: assert property (
    cycle_start_o == (phase_o == 2'h0)) else $error("cycle start");
  a_branch_mark: assert property (
    phase_o == 2'h1 |-> is_branch_o == $past(dec)) else $error("branch mark");
  c_taken: cover property (phase_o == 2'h2 && take);
  c_back_jump: cover property (program_counter_we_o && $past(instr_i[7], 2));
  c_flush: cover property ($rose(flush_o));
endmodule
bind cond_branch_on_flag_unit branch_unit_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// >>> tb/tb_cond_branch_on_flag_unit.sv
`timescale 1ns/10ps
module tb_cond_branch_on_flag_unit;
  import cond_branch_pkg::*;
  // ====================
  // Stimulus, scoreboard and clock.
  logic        sys_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        valid = 1'b0, n = 1'b0, v = 1'b0, z = 1'b0, c = 1'b0;
  logic        we, flush, swe, last_tk = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [20:0] addr, pc, want;
  logic [1:0]  phase;
  logic [31:0] lfsr = 32'h000105D2;
  logic [20:0] exp_q[$];
  logic [7:0]  ops[6] = '{8'hE6, 8'hE3, 8'hE7, 8'hE5, 8'hE1, 8'hE2};
  int          errors = 0, comparisons = 0, cycles = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  cond_branch_on_flag_unit DUT (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .instr_valid_i(valid), .instr_i(instr), .instr_addr_i(addr),
    .flag_negative_i(n), .flag_overflow_i(v), .flag_zero_i(z),
    .flag_carry_i(c), .program_counter_we_o(we), .program_counter_o(pc),
    .flush_o(flush), .is_branch_o(), .status_we_o(swe), .phase_o(phase),
    .cycle_start_o());
  fetch_pc_model PCM (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .phase_i(phase), .pc_we_i(we), .pc_i(pc), .addr_o(addr));
  // Prints the verdict and ends the run.
  task automatic final_report;
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Presents one instruction and notes the expected counter write.
  task automatic drive(input logic [7:0] op, input int k);
    logic tk;
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    instr = {op, (k == 0) ? 8'h80 : (k == 1) ? 8'h7F : lfsr[7:0]};
    {n, v, z, c} = lfsr[11:8];
    valid = 1'b1;
    tk = !last_tk && (op == OPC_BRANCH_IF_NEGATIVE && n
      || op == OPC_BRANCH_IF_CARRY_CLEAR && !c
      || op == OPC_BRANCH_IF_NOT_NEGATIVE && !n
      || op == OPC_BRANCH_IF_NO_OVERFLOW && !v
      || op == OPC_BRANCH_IF_NONZERO && !z);
    last_tk = tk;
    if (tk) exp_q.push_back(addr + 21'h2
      + {{12{instr[7]}}, instr[7:0], 1'b0});
  endtask
  // Back-to-back instructions aligned to phase zero.
  initial begin
    repeat (6) @(posedge sys_clk_i);
    #1 resetn_i = 1'b1;
    for (int i = 0; i < 150; i++) begin
      do begin
        @(posedge sys_clk_i);
        #1;
      end while (phase !== 2'h0);
      drive(ops[i % 6], i % 13);
    end
    repeat (8) @(posedge sys_clk_i);
    comparisons++;
    if (exp_q.size() != 0) begin
      errors++;
      $display("mismatch pending_writes expected 0 seen %0d", exp_q.size());
    end
    final_report();
  end
  // Compares every counter write with the oldest note.
  // Outputs are looked at on the falling edge, where they have settled.
  always @(negedge sys_clk_i) begin
    cycles++;
    if (swe !== 1'b0) begin
      errors++;
      $display("mismatch status_we_o expected 0 seen %b", swe);
    end
    if (we === 1'b1) begin
      comparisons++;
      want = (exp_q.size() != 0) ? exp_q.pop_front() : ~pc;
      if (pc !== want) begin
        errors++;
        $display("mismatch program_counter_o expected %h seen %h", want, pc);
      end
      if (flush !== 1'b1) begin
        errors++;
        $display("mismatch flush_o expected 1 seen %b", flush);
      end
    end
    if (cycles == 1000) begin
      errors++;
      final_report();
    end
  end
endmodule
